// ===== hdl/scs_brg.sv
// count source prescaler and reloadable bit-rate down counter
// assumes the sub clock arrives as a one-cycle tick synchronous to mclk
`timescale 1ns/1ps
module scs_brg import scs_pkg::*; #(
  parameter int RW = SCS_BRG_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [1:0] src_sel,
  input wire logic sub_tick,
  input wire logic [RW-1:0] reload,
  input wire logic run,
  output logic tick
);
  typedef struct packed {
    logic [4:0] pre;
    logic [RW-1:0] cnt;
    logic tick;
  } scs_brg_t;

  scs_brg_t st_r, st_nxt;
  logic src_hit;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pre = st_r.pre + 5'h01;
    st_nxt.tick = 1'b0;
    unique case (src_sel)
      SCS_SRC_F1: src_hit = 1'b1;
      SCS_SRC_F8: src_hit = (st_r.pre & SCS_PRE_MASK_F8) == SCS_PRE_MASK_F8;
      SCS_SRC_F32: src_hit = st_r.pre == SCS_PRE_MASK_F32;
      SCS_SRC_FC: src_hit = sub_tick;
    endcase
    // restart from the reload value so each transfer starts on a full period
    if (!run) begin
      st_nxt.cnt = reload;
    end else if (src_hit) begin
      if (st_r.cnt == '0) begin
        st_nxt.cnt = reload;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

  a_tick_source: assert property (
    @(posedge mclk) disable iff (sys_rst)
    tick |-> $past(src_hit) && $past(run))
    else $error("rate tick without a count source pulse");
  a_f32_spacing: assert property (
    @(posedge mclk) disable iff (sys_rst)
    tick && src_sel == SCS_SRC_F32 && $stable(src_sel) |=> !tick [*8])
    else $error("divide-by-32 source ticked too early");
endmodule

// ===== hdl/scs_fifo.sv
// small transmit buffer with valid/ready on both sides
// assumes the drain side may stall for any number of cycles
`timescale 1ns/1ps
module scs_fifo import scs_pkg::*; #(
  parameter int W = SCS_BITS,
  parameter int DEPTH = SCS_TXBUF_DEPTH
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("scs_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } scs_fifo_t;

  scs_fifo_t st_r, st_nxt;
  logic push, pop;

  always_comb begin
    st_nxt = st_r;
    push = in_valid && st_r.rdy;
    pop = (st_r.cnt != '0) && out_ready;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    st_nxt.rdy = st_nxt.cnt != DEPTH[AW:0];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready = st_r.rdy;
  assign out_valid = st_r.cnt != '0;
  assign out_data = st_r.mem[st_r.rp];

  a_full_holds: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !in_ready && !out_ready |=> !in_ready)
    else $error("buffer freed space without a drain");
  a_push_shows: assert property (
    @(posedge mclk) disable iff (sys_rst)
    in_valid && in_ready |=> out_valid)
    else $error("accepted word not visible at drain side");
endmodule

// ===== hdl/scs_pkg.sv
// shared constants and core state layout for the clock-synchronous serial unit
// assumes one 10 MHz system clock and a synchronous active-high reset
package scs_pkg;

  // -----------------------------------------------------------------
  // frame and timing
  // -----------------------------------------------------------------
  localparam int SCS_BITS = 8;
  localparam logic [3:0] SCS_BIT_LAST = 4'h8;
  localparam int SCS_TXBUF_DEPTH = 2;
  localparam int SCS_BRG_W = 8;

  // -----------------------------------------------------------------
  // count source select codes and prescaler masks
  // -----------------------------------------------------------------
  localparam logic [1:0] SCS_SRC_F1 = 2'h0;
  localparam logic [1:0] SCS_SRC_F8 = 2'h1;
  localparam logic [1:0] SCS_SRC_F32 = 2'h2;
  localparam logic [1:0] SCS_SRC_FC = 2'h3;
  localparam logic [4:0] SCS_PRE_MASK_F8 = 5'h07;
  localparam logic [4:0] SCS_PRE_MASK_F32 = 5'h1F;

  // -----------------------------------------------------------------
  // mode field, clock pin routing, dummy data
  // -----------------------------------------------------------------
  localparam logic [2:0] SCS_MODE_INVALID = 3'h0;
  localparam logic [2:0] SCS_MODE_SYNC = 3'h1;
  localparam logic [1:0] SCS_ALTERNATE_CLOCK_OUT_PIN_BOTH = 2'h3;
  localparam logic [7:0] SCS_DUMMY = 8'hFF;

  typedef enum logic {
    SCS_IDLE = 1'b0,
    SCS_RUN = 1'b1
  } scs_state_t;

  typedef struct packed {
    scs_state_t state;
    logic sclk;
    logic pin_prev;
    logic [3:0] bit_cnt;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic txd;
    logic [7:0] rx_buf;
    logic rx_full;
    logic ovr;
    logic tx_empty;
    logic tx_irq;
    logic rx_irq;
    logic arm;
    logic alt;
    logic pin_o;
    logic pin_oe_n;
    logic alt_o;
  } scs_core_t;

  // clock lines idle high, clock pin released, register empty
  localparam scs_core_t SCS_CORE_RST = '{
    state: SCS_IDLE, sclk: 1'b1, pin_prev: 1'b1, bit_cnt: 4'h0,
    tx_sh: 8'h00, rx_sh: 8'h00, txd: 1'b1, rx_buf: 8'h00,
    rx_full: 1'b0, ovr: 1'b0, tx_empty: 1'b1, tx_irq: 1'b0,
    rx_irq: 1'b0, arm: 1'b0, alt: 1'b0, pin_o: 1'b1,
    pin_oe_n: 1'b1, alt_o: 1'b1};

endpackage

// ===== hdl/scs_sync_serial.sv
// clock-synchronous 8-bit serial transmitter and receiver, channel zero
// assumes all pin and control inputs synchronous to mclk; no register bus
`timescale 1ns/1ps
module scs_sync_serial import scs_pkg::*; #(
  parameter int BRG_W = SCS_BRG_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sub_clk_tick,
  input wire logic clk_ext_sel,
  input wire logic [1:0] src_sel,
  input wire logic [BRG_W-1:0] brg_reload,
  input wire logic [2:0] mode_sel,
  input wire logic clk_pol,
  input wire logic msb_first,
  input wire logic cont_rx,
  input wire logic tx_irq_sel,
  input wire logic [1:0] clk_pin_sel,
  input wire logic tx_en,
  input wire logic rx_en,
  input wire logic tx_wr,
  input wire logic [7:0] tx_data,
  input wire logic rx_rd,
  input wire logic transfer_clock_pin_i,
  input wire logic serial_in_pin_ch0,
  output logic tx_buf_ready,
  output logic tx_reg_empty,
  output logic tx_irq,
  output logic [7:0] rx_data,
  output logic rx_done,
  output logic rx_irq,
  output logic rx_ovr,
  output logic transfer_clock_pin_o,
  output logic transfer_clock_pin_oe_n,
  output logic alternate_clock_out_pin,
  output logic serial_out_pin_ch0
);

  generate
    if (BRG_W < 1 || BRG_W > 16) begin : g_chk
      $error("scs_sync_serial rate counter width out of range");
    end
  endgenerate

  // ---------------------------------------------------------------
  // bit order helpers
  // ---------------------------------------------------------------
  function automatic logic pick_bit(input logic [7:0] b, input logic msb);
    pick_bit = msb ? b[7] : b[0];
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] b,
                                           input logic msb);
    shift_out = msb ? {b[6:0], 1'b0} : {1'b0, b[7:1]};
  endfunction

  // lsb-first frames enter at the top and move right
  function automatic logic [7:0] shift_in(input logic [7:0] b,
                                          input logic d,
                                          input logic msb);
    shift_in = msb ? {b[6:0], d} : {d, b[7:1]};
  endfunction

  // ---------------------------------------------------------------
  // state and submodules
  // ---------------------------------------------------------------
  scs_core_t st_r, n;

  logic fifo_vld, fifo_pop, brg_tick, brg_run;
  logic [7:0] fifo_data, load_byte;
  logic idle_lvl, active, pend, go, pin_moved, alt_ok;
  logic drv_ev, samp_ev, load_ev, done_ev, first_bit;

  scs_fifo #(
    .W(SCS_BITS),
    .DEPTH(SCS_TXBUF_DEPTH)
  ) u_txbuf (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(tx_wr),
    .in_data(tx_data),
    .in_ready(tx_buf_ready),
    .out_valid(fifo_vld),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  scs_brg #(
    .RW(BRG_W)
  ) u_brg (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .src_sel(src_sel),
    .sub_tick(sub_clk_tick),
    .reload(brg_reload),
    .run(brg_run),
    .tick(brg_tick)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    n = st_r;
    n.tx_irq = 1'b0;
    n.rx_irq = 1'b0;
    idle_lvl = ~clk_pol;
    // no second channel exists here, so tx_en and the mode code alone gate it
    active = tx_en && (mode_sel == SCS_MODE_SYNC);
    // successive mode substitutes dummy data after each buffer read when no byte is queued
    pend = fifo_vld || (cont_rx && st_r.arm);
    load_byte = fifo_vld ? fifo_data : SCS_DUMMY;
    first_bit = pick_bit(load_byte, msb_first);
    alt_ok = (clk_pin_sel == SCS_ALTERNATE_CLOCK_OUT_PIN_BOTH) && !clk_ext_sel;
    pin_moved = transfer_clock_pin_i != st_r.pin_prev;
    n.pin_prev = transfer_clock_pin_i;
    brg_run = (st_r.state == SCS_RUN) || (active && pend);
    go = 1'b0;

    // edges: leaving idle level drives, returning to it samples
    if (clk_ext_sel) begin
      drv_ev = pin_moved && (st_r.pin_prev == idle_lvl);
      samp_ev = pin_moved && (st_r.pin_prev != idle_lvl);
      n.sclk = idle_lvl;
    end else begin
      go = brg_tick && brg_run;
      drv_ev = go && (st_r.sclk == idle_lvl);
      samp_ev = go && (st_r.sclk != idle_lvl);
      if (go) begin
        n.sclk = ~st_r.sclk;
      end else if (st_r.state == SCS_IDLE) begin
        n.sclk = idle_lvl;
      end
    end

    load_ev = drv_ev && active && pend &&
              ((st_r.state == SCS_IDLE) ||
               (st_r.bit_cnt == SCS_BIT_LAST));
    fifo_pop = load_ev && fifo_vld;
    done_ev = samp_ev && (st_r.state == SCS_RUN) &&
              (st_r.bit_cnt == SCS_BIT_LAST - 4'h1);

    // ---- transmit side
    if (load_ev) begin
      n.state = SCS_RUN;
      n.bit_cnt = 4'h0;
      n.tx_sh = load_byte;
      n.txd = first_bit;
      n.tx_empty = 1'b0;
      n.arm = 1'b0;
      if (!tx_irq_sel) begin
        n.tx_irq = 1'b1;
      end
    end else if (drv_ev && st_r.state == SCS_RUN) begin
      if (st_r.bit_cnt == SCS_BIT_LAST) begin
        n.state = SCS_IDLE;
      end else begin
        n.tx_sh = shift_out(st_r.tx_sh, msb_first);
        n.txd = pick_bit(n.tx_sh, msb_first);
      end
    end

    // ---- sample side
    if (samp_ev && st_r.state == SCS_RUN &&
        st_r.bit_cnt != SCS_BIT_LAST) begin
      n.rx_sh = shift_in(st_r.rx_sh, serial_in_pin_ch0,
                         msb_first);
      n.bit_cnt = st_r.bit_cnt + 4'h1;
    end
    if (done_ev) begin
      n.tx_empty = 1'b1;
      if (tx_irq_sel) begin
        n.tx_irq = 1'b1;
      end
      // clock parks at idle unless another byte is waiting
      if (!(active && pend)) begin
        n.state = SCS_IDLE;
      end
    end

    // ---- receive buffer; a completing byte beats a same-cycle clear
    if (rx_rd) begin
      n.rx_full = 1'b0;
      if (cont_rx) begin
        n.arm = 1'b1;
      end
    end
    if (!rx_en && mode_sel == SCS_MODE_INVALID) begin
      n.rx_full = 1'b0;
      n.ovr = 1'b0;
    end
    if (done_ev && rx_en) begin
      if (st_r.rx_full && !rx_rd) begin
        n.ovr = 1'b1;
      end
      n.rx_buf = n.rx_sh;
      n.rx_full = 1'b1;
      n.rx_irq = 1'b1;
    end

    // ---- pin routing; the alternate pin is only taken up between transfers, external clock select acts at once
    if (st_r.state == SCS_IDLE) begin
      n.alt = alt_ok;
    end else begin
      n.alt = st_r.alt && !clk_ext_sel;
    end
    n.pin_oe_n = clk_ext_sel;
    n.pin_o = n.alt ? idle_lvl : n.sclk;
    n.alt_o = n.alt ? n.sclk : idle_lvl;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= SCS_CORE_RST;
    end else begin
      st_r <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign tx_reg_empty = st_r.tx_empty;
  assign tx_irq = st_r.tx_irq;
  assign rx_data = st_r.rx_buf;
  assign rx_done = st_r.rx_full;
  assign rx_irq = st_r.rx_irq;
  assign rx_ovr = st_r.ovr;
  assign transfer_clock_pin_o = st_r.pin_o;
  assign transfer_clock_pin_oe_n = st_r.pin_oe_n;
  assign alternate_clock_out_pin = st_r.alt_o;
  assign serial_out_pin_ch0 = st_r.txd;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_rx_done;
    done_ev && rx_en;
  endsequence

  sequence s_rx_post;
    rx_done && rx_irq ##1 !rx_irq;
  endsequence

  a_overrun_set: assert property (
    done_ev && rx_en && rx_done && !rx_rd |=> rx_ovr)
    else $error("overrun not flagged");
  a_overrun_hold: assert property (
    rx_ovr && (rx_en || mode_sel != SCS_MODE_INVALID) |=> rx_ovr)
    else $error("overrun flag dropped before reinit");
  a_rx_clear: assert property (
    rx_rd && !done_ev |=> !rx_done)
    else $error("read did not clear receive-complete");
  a_rx_frame: assert property (
    s_rx_done |=> s_rx_post)
    else $error("receive completion not reported");
  a_tx_empty: assert property (
    done_ev |=> tx_reg_empty && st_r.bit_cnt == SCS_BIT_LAST)
    else $error("register-empty not set after bit eight");
  a_idle_level: assert property (
    st_r.state == SCS_IDLE && !go |=> st_r.sclk == $past(idle_lvl))
    else $error("idle clock not parked at idle level");
  a_rate_half: assert property (
    !clk_ext_sel && !brg_tick |=> st_r.sclk == $past(st_r.sclk) ||
                                  st_r.state == SCS_IDLE)
    else $error("internal clock moved without a rate tick");
  a_first_bit: assert property (
    load_ev |=> serial_out_pin_ch0 == $past(first_bit))
    else $error("wrong first bit for bit order");
  a_load_irq: assert property (
    load_ev && !tx_irq_sel |=> tx_irq ##1 !tx_irq)
    else $error("buffer-empty interrupt missing");
  a_done_irq: assert property (
    done_ev && tx_irq_sel |=> tx_irq)
    else $error("completion interrupt missing");
  a_alt_gate: assert property (
    $rose(st_r.alt) |-> $past(alt_ok) && $past(st_r.state) == SCS_IDLE)
    else $error("alternate clock pin selected illegally");
  a_ext_shift: assert property (
    clk_ext_sel && !pin_moved |=> $stable(st_r.bit_cnt))
    else $error("shift without an external clock edge");
  a_back_back: assert property (
    done_ev && active && fifo_vld |=> st_r.state == SCS_RUN)
    else $error("queued byte did not follow directly");
  a_mode_gate: assert property (
    st_r.state == SCS_IDLE && mode_sel != SCS_MODE_SYNC |=>
      st_r.state == SCS_IDLE)
    else $error("transfer started outside synchronous mode");
endmodule

// ===== sim/scs_far_ic.sv
// far-side serial device: shifts one byte out and one byte in per frame
// assumes sclk is the resolved clock line and every input follows mclk
`timescale 1ns/1ps
module scs_far_ic #(
  parameter logic [3:0] HALF = 4'h5
) (
  input wire logic mclk,
  input wire logic clr,
  input wire logic sclk,
  input wire logic pol,
  input wire logic msb,
  input wire logic din,
  input wire logic [7:0] tx_byte,
  input wire logic ext_go,
  output logic dout,
  output logic ext_clk,
  output logic [7:0] cap
);
  // -----------------------------------------------------------------
  // frame shifting and applied clock
  // -----------------------------------------------------------------
  logic prev = 1'b1;
  logic [3:0] nbit = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] cur;
  logic [4:0] edges = 5'h00;
  logic [3:0] hc = 4'h0;
  initial dout = 1'b0;
  initial ext_clk = 1'b1;
  initial cap = 8'h00;
  assign cur = (nbit[2:0] == 3'h0) ? tx_byte : sh;
  always @(posedge mclk) begin
    prev <= sclk;
    if (clr) begin
      nbit <= 4'h0;
    end else if (sclk !== prev && sclk === pol) begin
      dout <= msb ? cur[7] : cur[0];
      sh <= msb ? {cur[6:0], 1'b0} : {1'b0, cur[7:1]};
    end else if (sclk !== prev) begin
      cap <= msb ? {cap[6:0], din} : {din, cap[7:1]};
      nbit <= nbit + 4'h1;
      // a released line must not keep showing its last bit
      if (nbit[2:0] == 3'h7) dout <= ~dout;
    end
  end
  always @(posedge mclk) begin
    if (!ext_go) begin
      ext_clk <= ~pol;
      edges <= 5'h00;
      hc <= 4'h0;
    end else if (edges != 5'h10) begin
      hc <= (hc == HALF) ? 4'h0 : hc + 4'h1;
      if (hc == HALF) begin
        ext_clk <= ~ext_clk;
        edges <= edges + 5'h01;
      end
    end
  end
endmodule

// ===== sim/tb_scs_sync_serial.sv
// self-checking bench for the clock-synchronous serial unit
// assumes scs_far_ic on the pins; controls and flags are plain ports
`timescale 1ns/1ps
module tb_scs_sync_serial import scs_pkg::*;;
  // -----------------------------------------------------------------
  // stimulus, wiring, monitors
  // -----------------------------------------------------------------
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic sub_tick = 1'b0;
  logic [1:0] sub_cnt = 2'h0;
  logic ext_sel = 1'b0;
  logic [1:0] src = SCS_SRC_F1;
  logic [7:0] reload = 8'h03;
  logic [2:0] mode = SCS_MODE_SYNC;
  logic pol = 1'b0;
  logic msb = 1'b0;
  logic cont = 1'b0;
  logic irq_sel = 1'b0;
  logic [1:0] pin_sel = 2'h0;
  logic tx_en = 1'b1;
  logic rx_en = 1'b1;
  logic tx_wr = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic rx_rd = 1'b0;
  logic [7:0] far_byte = 8'h00;
  logic ext_go = 1'b0;
  logic clr = 1'b0;
  logic buf_rdy, reg_empty, tx_irq, rx_done, rx_irq, rx_ovr;
  logic pin_o, oe_n, alt_o, s_out, s_in, ext_clk, sclk, pin_i;
  logic [7:0] rx_data, cap;
  logic prev_alt = 1'b1;
  logic prev_pin = 1'b1;
  logic irq_empty = 1'b0;
  logic [15:0] dur;
  int n_fail = 0;
  int check_count = 0;
  int n_txirq = 0;
  int n_rxirq = 0;
  int n_alt = 0;
  int n_pin = 0;
  int cyc = 0;
  assign pin_i = oe_n ? ext_clk : pin_o;
  assign sclk = ext_sel ? ext_clk : (pin_sel == SCS_ALTERNATE_CLOCK_OUT_PIN_BOTH) ? alt_o : pin_o;
  scs_sync_serial #(.BRG_W(8)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .sub_clk_tick(sub_tick),
    .clk_ext_sel(ext_sel), .src_sel(src), .brg_reload(reload),
    .mode_sel(mode), .clk_pol(pol), .msb_first(msb), .cont_rx(cont),
    .tx_irq_sel(irq_sel), .clk_pin_sel(pin_sel), .tx_en(tx_en),
    .rx_en(rx_en), .tx_wr(tx_wr), .tx_data(tx_data), .rx_rd(rx_rd),
    .transfer_clock_pin_i(pin_i), .serial_in_pin_ch0(s_in),
    .tx_buf_ready(buf_rdy), .tx_reg_empty(reg_empty), .tx_irq(tx_irq),
    .rx_data(rx_data), .rx_done(rx_done), .rx_irq(rx_irq),
    .rx_ovr(rx_ovr), .transfer_clock_pin_o(pin_o),
    .transfer_clock_pin_oe_n(oe_n), .alternate_clock_out_pin(alt_o),
    .serial_out_pin_ch0(s_out));
  scs_far_ic far (
    .mclk(mclk), .clr(clr), .sclk(sclk), .pol(pol), .msb(msb),
    .din(s_out), .tx_byte(far_byte), .ext_go(ext_go), .dout(s_in),
    .ext_clk(ext_clk), .cap(cap));
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    sub_cnt <= sub_cnt + 2'h1;
    sub_tick <= (sub_cnt == 2'h3);
    prev_alt <= alt_o;
    prev_pin <= pin_o;
    if (alt_o !== prev_alt) n_alt <= n_alt + 1;
    if (pin_o !== prev_pin) n_pin <= n_pin + 1;
    if (rx_irq === 1'b1) n_rxirq <= n_rxirq + 1;
    if (tx_irq === 1'b1) begin
      n_txirq <= n_txirq + 1;
      irq_empty <= reg_empty;
    end
    cyc <= cyc + 1;
    // generous ceiling: the whole sequence needs under 6000 cycles
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end
  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic chk_v(input string what, input logic [15:0] e,
      input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic chk1(input string what, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %b got %b", what, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] b);
    @(posedge mclk);
    tx_wr <= 1'b1;
    tx_data <= b;
    @(posedge mclk);
    tx_wr <= 1'b0;
  endtask
  task automatic rd;
    @(posedge mclk);
    rx_rd <= 1'b1;
    @(posedge mclk);
    rx_rd <= 1'b0;
  endtask
  task automatic clr_far;
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
  endtask
  // dur: cycles from shift register load to empty again
  task automatic wait_done;
    int i;
    i = 0;
    dur = 16'h0000;
    do begin
      step(1);
      i++;
    end while (reg_empty !== 1'b0 && i < 400);
    do begin
      step(1);
      i++;
      dur++;
    end while (reg_empty !== 1'b1 && i < 3000);
    chk1("finished", 1'b1, reg_empty);
    step(2);
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_reset;
    step(2);
    chk1("buf_rdy", 1'b1, buf_rdy);
    chk1("reg_empty", 1'b1, reg_empty);
    chk1("clk_idle", 1'b1, pin_o);
    chk1("oe_n", 1'b0, oe_n);
    chk1("alt_idle", 1'b1, alt_o);
    chk1("rx_done", 1'b0, rx_done);
    chk1("rx_ovr", 1'b0, rx_ovr);
  endtask
  task automatic t_basic;
    int t0;
    @(posedge mclk);
    tx_en <= 1'b0;
    far_byte <= 8'h3D;
    clr_far();
    wr(8'hA7);
    step(40);
    chk1("held", 1'b1, reg_empty);
    t0 = n_txirq + n_rxirq;
    @(posedge mclk);
    tx_en <= 1'b1;
    wait_done();
    chk_v("dur", 16'h003C, dur);
    chk_v("far_cap", 16'h00A7, {8'h00, cap});
    chk_v("rx_data", 16'h003D, {8'h00, rx_data});
    chk1("rx_done", 1'b1, rx_done);
    chk1("irq_move", 1'b0, irq_empty);
    chk_v("irqs", 16'h0002, 16'(n_txirq + n_rxirq - t0));
    step(20);
    chk1("clk_stop", 1'b1, sclk);
    rd();
    step(30);
    chk1("rd_clear", 1'b0, rx_done);
    chk1("no_arm", 1'b1, reg_empty);
  endtask
  // register-empty blinks between queued bytes, so each byte is awaited
  task automatic t_b2b;
    int t1;
    @(posedge mclk);
    msb <= 1'b1;
    far_byte <= 8'h8E;
    clr_far();
    wr(8'h12);
    wr(8'hC6);
    wait_done();
    chk_v("far_cap1", 16'h0012, {8'h00, cap});
    t1 = cyc;
    wait_done();
    chk_v("dur_b2b", 16'h0040, 16'(cyc - t1));
    chk_v("far_cap", 16'h00C6, {8'h00, cap});
    chk1("ovr_set", 1'b1, rx_ovr);
    chk_v("rx_data", 16'h008E, {8'h00, rx_data});
    rd();
    step(2);
    chk1("ovr_kept", 1'b1, rx_ovr);
    @(posedge mclk);
    rx_en <= 1'b0;
    mode <= SCS_MODE_INVALID;
    @(posedge mclk);
    mode <= SCS_MODE_SYNC;
    rx_en <= 1'b1;
    msb <= 1'b0;
    step(2);
    chk1("ovr_clr", 1'b0, rx_ovr);
    chk1("done_clr", 1'b0, rx_done);
  endtask
  task automatic t_ext;
    @(posedge mclk);
    ext_sel <= 1'b1;
    pol <= 1'b1;
    far_byte <= 8'h4B;
    step(3);
    chk1("oe_off", 1'b1, oe_n);
    clr_far();
    wr(8'h96);
    @(posedge mclk);
    ext_go <= 1'b1;
    wait_done();
    chk_v("far_cap", 16'h0096, {8'h00, cap});
    chk_v("rx_data", 16'h004B, {8'h00, rx_data});
    @(posedge mclk);
    ext_go <= 1'b0;
    ext_sel <= 1'b0;
    pol <= 1'b0;
    rd();
  endtask
  task automatic t_alt;
    int a0;
    int p0;
    @(posedge mclk);
    pin_sel <= SCS_ALTERNATE_CLOCK_OUT_PIN_BOTH;
    irq_sel <= 1'b1;
    step(3);
    clr_far();
    a0 = n_alt;
    p0 = n_pin;
    wr(8'h3E);
    wait_done();
    chk_v("alt_edges", 16'h0010, 16'(n_alt - a0));
    chk_v("pin_edges", 16'h0000, 16'(n_pin - p0));
    chk_v("far_cap", 16'h003E, {8'h00, cap});
    chk1("irq_end", 1'b1, irq_empty);
    @(posedge mclk);
    pin_sel <= 2'h0;
    irq_sel <= 1'b0;
    rd();
  endtask
  task automatic t_succ;
    @(posedge mclk);
    cont <= 1'b1;
    far_byte <= 8'h1D;
    clr_far();
    rd();
    wait_done();
    chk_v("dummy", {8'h00, SCS_DUMMY}, {8'h00, cap});
    chk_v("rx_data", 16'h001D, {8'h00, rx_data});
    @(posedge mclk);
    far_byte <= 8'hB4;
    rd();
    wait_done();
    chk_v("rearm", 16'h00B4, {8'h00, rx_data});
    chk1("no_ovr", 1'b0, rx_ovr);
    @(posedge mclk);
    cont <= 1'b0;
    rd();
  endtask
  // first drive to last sample: 15 half periods x (n+1) x source divide
  task automatic t_rate;
    logic [15:0] div;
    @(posedge mclk);
    reload <= 8'h01;
    rx_en <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      div = (s == 0) ? 16'h0001 : (s == 1) ? 16'h0008 :
        (s == 2) ? 16'h0020 : 16'h0004;
      @(posedge mclk);
      src <= 2'(s);
      wr(8'h55);
      wait_done();
      chk_v("dur_src", 16'(div * 16'h001E), dur);
    end
  endtask
  // pending byte under external clock is flushed by the internal clock
  task automatic t_flush;
    @(posedge mclk);
    ext_sel <= 1'b1;
    step(3);
    clr_far();
    wr(8'hC3);
    step(20);
    chk1("ext_hold", 1'b1, reg_empty);
    @(posedge mclk);
    ext_sel <= 1'b0;
    wait_done();
    @(posedge mclk);
    ext_sel <= 1'b1;
    step(3);
    clr_far();
    wr(8'h69);
    @(posedge mclk);
    ext_go <= 1'b1;
    wait_done();
    chk_v("far_cap", 16'h0069, {8'h00, cap});
    @(posedge mclk);
    ext_go <= 1'b0;
    ext_sel <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_basic();
    t_b2b();
    t_ext();
    t_alt();
    t_succ();
    t_rate();
    t_flush();
    summarize();
  end
endmodule
